//--- hw/olb_overlay_blender.sv
// olb_overlay_blender: overlay window geometry, strides, default colour, chroma key, blender and channel control.
// assumes a single-cycle register master and frame timing pulses from the display timing generator.
`timescale 1ns/1ps
`default_nettype none
module olb_overlay_blender #(
   parameter int ADDR_W = 32
) (
   // clock and reset
   input  wire  logic                  clk_sys_in,
   input  wire  logic                  rst_in,
   // register port
   input  wire  logic [31:0]           reg_addr_in,
   input  wire  logic [31:0]           reg_wdata_in,
   input  wire  logic                  reg_wr_in,
   input  wire  logic                  reg_rd_in,
   output logic       [31:0]           reg_rdata_out,
   // frame timing and display geometry
   input  wire  logic                  frame_start_in,
   input  wire  logic                  frame_done_in,
   input  wire  logic [10:0]           win_left_in,
   input  wire  logic [10:0]           win_top_in,
   input  wire  logic [11:0]           pixels_per_line_in,
   input  wire  logic [11:0]           rows_per_frame_in,
   output logic       [11:0]           win_width_out,
   output logic       [11:0]           win_height_out,
   output logic                        geometry_err_out,
   // descriptor queue
   output logic                        queue_push_req_out,
   input  wire  logic                  head_queued_in,
   // channel state
   output logic                        channel_on_out,
   output logic                        channel_abort_out,
   // fetch address stream
   input  wire  logic [ADDR_W-1:0]     base_addr_in,
   output logic                        fetch_valid_out,
   output logic       [ADDR_W-1:0]     fetch_addr_out,
   input  wire  logic                  fetch_ready_in,
   // pixel path
   input  wire  logic                  pix_valid_in,
   input  wire  olb_pkg::olb_argb_s    mem_pix_in,
   input  wire  logic [3:0]            comp_depth_in,
   input  wire  olb_pkg::olb_rgb_s     under_pix_in,
   output logic                        pix_valid_out,
   output olb_pkg::olb_rgb_s           pix_out
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // colour component width; narrower depths are widened to it
   localparam int COMP_W = $bits(mem_pix_in.alpha);

   function automatic logic [7:0] expand(input logic [7:0] c, input logic [3:0] depth, input logic copy);
      logic [7:0] r;
      int         i;
      r = c;
      // zero depth has no bits to widen, so it passes through untouched
      if (depth != 4'h0 && depth < olb_pkg::FULL_DEPTH) begin
         r = 8'h00;
         for (i = 0; i < COMP_W; i++) begin
            if (i >= (COMP_W - int'(depth))) begin
               r[i] = c[i - (COMP_W - int'(depth))];
            end else begin
               r[i] = copy & c[int'(depth) - 1];
            end
         end
      end
      return r;
   endfunction

   function automatic logic key_hit(input olb_pkg::olb_rgb_s p, input logic [23:0] key, input logic [23:0] mask);
      return (((p ^ key) & mask) == 24'h000000);
   endfunction

   // rounded to nearest to halve the truncation error of the byte product
   function automatic logic [7:0] scale(input logic [7:0] v, input logic [7:0] a);
      logic [15:0] p;
      p = v * a;
      return p[15:8] + {7'h00, p[7]};
   endfunction

   function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      logic [9:0] s;
      s = {2'b00, a} + {2'b00, b} + {2'b00, c};
      return (s > {2'b00, olb_pkg::COMP_MAX}) ? olb_pkg::COMP_MAX : s[7:0];
   endfunction

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   logic [31:0] win_size_reg;
   logic [31:0] win_active_reg;
   logic [31:0] row_step_reg;
   logic [31:0] pixel_step_reg;
   logic [31:0] def_colour_reg;
   logic [31:0] key_colour_reg;
   logic [31:0] key_mask_reg;
   logic [31:0] ctrl_reg;
   logic        channel_on_reg;
   logic        off_pending_reg;
   logic        refresh_pending_reg;
   logic        qpush_pending_reg;
   logic        abort_reg;

   wire logic wr_on  = reg_wr_in && (reg_addr_in == olb_pkg::ADDR_CHAN_ON);
   wire logic wr_off = reg_wr_in && (reg_addr_in == olb_pkg::ADDR_CHAN_OFF);
   // abort rides on the disable register and beats every other command
   wire logic abort_now = wr_off && reg_wdata_in[olb_pkg::B_CH_ABORT];

   // reserved bits are masked on write so they read back as zero
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         win_size_reg   <= 32'h00000000;
         row_step_reg   <= 32'h00000000;
         pixel_step_reg <= 32'h00000000;
         def_colour_reg <= 32'h00000000;
         key_colour_reg <= 32'h00000000;
         key_mask_reg   <= 32'h00000000;
         ctrl_reg       <= 32'h00000000;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            olb_pkg::ADDR_WIN_SIZE:   win_size_reg   <= reg_wdata_in & olb_pkg::WIN_MASK;
            olb_pkg::ADDR_ROW_STEP:   row_step_reg   <= reg_wdata_in;
            olb_pkg::ADDR_PIX_STEP:   pixel_step_reg <= reg_wdata_in;
            olb_pkg::ADDR_DEF_COLOUR: def_colour_reg <= reg_wdata_in & olb_pkg::COLOUR_MASK;
            olb_pkg::ADDR_KEY_COLOUR: key_colour_reg <= reg_wdata_in & olb_pkg::COLOUR_MASK;
            olb_pkg::ADDR_KEY_MASK:   key_mask_reg   <= reg_wdata_in & olb_pkg::COLOUR_MASK;
            olb_pkg::ADDR_BLEND_CTRL: ctrl_reg       <= reg_wdata_in & olb_pkg::CTRL_MASK;
            default: ;
         endcase
      end
   end

   // window geometry only takes effect at a frame start after a refresh request, so a frame never tears
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         win_active_reg      <= 32'h00000000;
         refresh_pending_reg <= 1'b0;
      end else if (abort_now) begin
         refresh_pending_reg <= 1'b0;
      end else if (frame_start_in && refresh_pending_reg) begin
         win_active_reg      <= win_size_reg;
         refresh_pending_reg <= wr_on && reg_wdata_in[olb_pkg::B_REFRESH];
      end else if (wr_on && reg_wdata_in[olb_pkg::B_REFRESH]) begin
         refresh_pending_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // channel control
   // ----------------------------------------
   // an enable write cancels a pending disable
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         channel_on_reg  <= 1'b0;
         off_pending_reg <= 1'b0;
         abort_reg       <= 1'b0;
      end else begin
         abort_reg <= abort_now;
         if (abort_now) begin
            channel_on_reg  <= 1'b0;
            off_pending_reg <= 1'b0;
         end else if (wr_on && reg_wdata_in[olb_pkg::B_CH_ON]) begin
            channel_on_reg  <= 1'b1;
            off_pending_reg <= 1'b0;
         end else if (wr_off && reg_wdata_in[olb_pkg::B_CH_OFF]) begin
            off_pending_reg <= channel_on_reg;
         end else if (off_pending_reg && frame_done_in) begin
            channel_on_reg  <= 1'b0;
            off_pending_reg <= 1'b0;
         end
      end
   end

   // a new push request in the same cycle as the queued pulse keeps the request standing
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || abort_now) begin
         qpush_pending_reg <= 1'b0;
      end else if (wr_on && reg_wdata_in[olb_pkg::B_QPUSH]) begin
         qpush_pending_reg <= 1'b1;
      end else if (head_queued_in) begin
         qpush_pending_reg <= 1'b0;
      end
   end

   assign queue_push_req_out = qpush_pending_reg;
   assign channel_on_out     = channel_on_reg;
   assign channel_abort_out  = abort_reg;

   // ----------------------------------------
   // window geometry
   // ----------------------------------------
   // a bad setting is only flagged on geometry_err_out, the window is never clamped
   wire logic [10:0] width_f  = win_active_reg[olb_pkg::WIDTH_LSB +: olb_pkg::SIZE_W];
   wire logic [10:0] height_f = win_active_reg[olb_pkg::HEIGHT_LSB +: olb_pkg::SIZE_W];

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         win_width_out    <= 12'h000;
         win_height_out   <= 12'h000;
         geometry_err_out <= 1'b0;
      end else begin
         win_width_out    <= {1'b0, width_f} + 12'h001;
         win_height_out   <= {1'b0, height_f} + 12'h001;
         geometry_err_out <= (({1'b0, win_left_in} + {1'b0, width_f}) > pixels_per_line_in) ||
                             (({1'b0, win_top_in} + {1'b0, height_f}) > rows_per_frame_in);
      end
   end

   // ----------------------------------------
   // fetch address generator
   // ----------------------------------------
   // counters run up to the fields, one less than the window size
   olb_pkg::olb_fetch_e fetch_state_reg;
   logic [10:0]         col_reg;
   logic [10:0]         row_reg;
   wire logic dma_run = channel_on_reg && ctrl_reg[olb_pkg::B_DMA_ON];

   always_ff @(posedge clk_sys_in) begin
      if (rst_in || abort_now) begin
         fetch_state_reg <= olb_pkg::OLB_IDLE;
         fetch_addr_out  <= '0;
         col_reg         <= 11'h000;
         row_reg         <= 11'h000;
      end else begin
         unique case (fetch_state_reg)
            olb_pkg::OLB_IDLE: begin
               if (frame_start_in && dma_run) begin
                  fetch_state_reg <= olb_pkg::OLB_FETCH;
                  fetch_addr_out  <= base_addr_in;
                  col_reg         <= 11'h000;
                  row_reg         <= 11'h000;
               end
            end
            olb_pkg::OLB_FETCH: begin
               if (fetch_ready_in) begin
                  if (col_reg != width_f) begin
                     col_reg        <= col_reg + 11'h001;
                     fetch_addr_out <= fetch_addr_out + pixel_step_reg[ADDR_W-1:0];
                  end else if (row_reg != height_f) begin
                     col_reg        <= 11'h000;
                     row_reg        <= row_reg + 11'h001;
                     fetch_addr_out <= fetch_addr_out + row_step_reg[ADDR_W-1:0];
                  end else begin
                     fetch_state_reg <= olb_pkg::OLB_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // the last ready edge returns to idle; frame starts while busy are ignored
   assign fetch_valid_out = (fetch_state_reg == olb_pkg::OLB_FETCH);

   // ----------------------------------------
   // pixel path
   // ----------------------------------------
   olb_pkg::olb_rgb_s feedback_difference_sel_reg;
   olb_pkg::olb_rgb_s ovr_pix;
   olb_pkg::olb_rgb_s mem_rgb;
   olb_pkg::olb_rgb_s mixed;
   olb_pkg::olb_rgb_s result;
   logic [7:0]        alpha;
   logic [7:0]        alpha_d;
   logic              keyed;

   always_comb begin
      mem_rgb.red   = expand(mem_pix_in.rgb.red,   comp_depth_in, ctrl_reg[olb_pkg::B_LSB_COPY]);
      mem_rgb.green = expand(mem_pix_in.rgb.green, comp_depth_in, ctrl_reg[olb_pkg::B_LSB_COPY]);
      mem_rgb.blue  = expand(mem_pix_in.rgb.blue,  comp_depth_in, ctrl_reg[olb_pkg::B_LSB_COPY]);
      if (dma_run && ctrl_reg[olb_pkg::B_OVR_SRC]) begin
         ovr_pix = mem_rgb;
      end else begin
         ovr_pix = def_colour_reg[23:0];
      end
      alpha = olb_pkg::COMP_MAX;
      if (ctrl_reg[olb_pkg::B_GA_ON]) begin
         alpha = ctrl_reg[olb_pkg::GA_LSB +: 8];
      end
      if (ctrl_reg[olb_pkg::B_LA_ON]) begin
         alpha = scale(alpha, mem_pix_in.alpha);
      end
      alpha_d = ctrl_reg[olb_pkg::B_ALPHA_CPL] ? (olb_pkg::COMP_MAX - alpha) : alpha;
      keyed = 1'b0;
      if (ctrl_reg[olb_pkg::B_KEYING]) begin
         keyed = ctrl_reg[olb_pkg::B_DEST_KEY] ?
                 !key_hit(under_pix_in, key_colour_reg[23:0], key_mask_reg[23:0]) :
                 key_hit(ovr_pix, key_colour_reg[23:0], key_mask_reg[23:0]);
      end
      mixed.red   = sat_add(scale(ovr_pix.red, alpha),
                            scale(under_pix_in.red, olb_pkg::COMP_MAX - alpha), 8'h00);
      mixed.green = sat_add(scale(ovr_pix.green, alpha),
                            scale(under_pix_in.green, olb_pkg::COMP_MAX - alpha), 8'h00);
      mixed.blue  = sat_add(scale(ovr_pix.blue, alpha),
                            scale(under_pix_in.blue, olb_pkg::COMP_MAX - alpha), 8'h00);
      // adder operand and scaled difference both come from the iterated pixel of the previous output
      result.red   = sat_add(mixed.red,
                             ctrl_reg[olb_pkg::B_ADD_SEL] ? feedback_difference_sel_reg.red : 8'h00,
                             scale(ctrl_reg[olb_pkg::B_DIFF_SEL] ? feedback_difference_sel_reg.red : 8'h00, alpha_d));
      result.green = sat_add(mixed.green,
                             ctrl_reg[olb_pkg::B_ADD_SEL] ? feedback_difference_sel_reg.green : 8'h00,
                             scale(ctrl_reg[olb_pkg::B_DIFF_SEL] ? feedback_difference_sel_reg.green : 8'h00, alpha_d));
      result.blue  = sat_add(mixed.blue,
                             ctrl_reg[olb_pkg::B_ADD_SEL] ? feedback_difference_sel_reg.blue : 8'h00,
                             scale(ctrl_reg[olb_pkg::B_DIFF_SEL] ? feedback_difference_sel_reg.blue : 8'h00, alpha_d));
      if (keyed) begin
         result = under_pix_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in || abort_now) begin
         pix_valid_out <= 1'b0;
         pix_out       <= '0;
         feedback_difference_sel_reg      <= '0;
      end else begin
         pix_valid_out <= pix_valid_in;
         // iterated pixel moves only on valid pixels, so stream gaps keep it
         if (pix_valid_in) begin
            pix_out  <= result;
            feedback_difference_sel_reg <= ctrl_reg[olb_pkg::B_NEGATE] ? ~result : result;
         end
      end
   end

   // ----------------------------------------
   // register read
   // ----------------------------------------
   // command registers are write-only and read as zero like unmapped holes
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         reg_rdata_out <= 32'h00000000;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            olb_pkg::ADDR_WIN_SIZE:   reg_rdata_out <= win_size_reg;
            olb_pkg::ADDR_ROW_STEP:   reg_rdata_out <= row_step_reg;
            olb_pkg::ADDR_PIX_STEP:   reg_rdata_out <= pixel_step_reg;
            olb_pkg::ADDR_DEF_COLOUR: reg_rdata_out <= def_colour_reg;
            olb_pkg::ADDR_KEY_COLOUR: reg_rdata_out <= key_colour_reg;
            olb_pkg::ADDR_KEY_MASK:   reg_rdata_out <= key_mask_reg;
            olb_pkg::ADDR_BLEND_CTRL: reg_rdata_out <= ctrl_reg;
            olb_pkg::ADDR_CHAN_STAT:  reg_rdata_out <= {29'h00000000, qpush_pending_reg,
                                                        refresh_pending_reg, channel_on_reg};
            default:                  reg_rdata_out <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_out <= 32'h00000000;
      end
   end
endmodule // olb_overlay_blender
`default_nettype wire

//--- inc/olb_pkg.sv
// olb_pkg: register map, field positions and pixel types for the overlay blender configuration block.
// assumes byte addressing on a 32-bit register port.
package olb_pkg;
   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [31:0] ADDR_WIN_SIZE   = 32'hF8038138;
   localparam logic [31:0] ADDR_ROW_STEP   = 32'hF803813C;
   localparam logic [31:0] ADDR_PIX_STEP   = 32'hF8038140;
   localparam logic [31:0] ADDR_DEF_COLOUR = 32'hF8038144;
   localparam logic [31:0] ADDR_KEY_COLOUR = 32'hF8038148;
   localparam logic [31:0] ADDR_KEY_MASK   = 32'hF803814C;
   localparam logic [31:0] ADDR_BLEND_CTRL = 32'hF8038150;
   localparam logic [31:0] ADDR_CHAN_ON    = 32'hF8038280;
   localparam logic [31:0] ADDR_CHAN_OFF   = 32'hF8038284;
   localparam logic [31:0] ADDR_CHAN_STAT  = 32'hF8038288;
   // ----------------------------------------
   // field positions and widths
   // ----------------------------------------
   localparam int          SIZE_W      = 11;
   localparam int          WIDTH_LSB   = 0;
   localparam int          HEIGHT_LSB  = 16;
   localparam logic [31:0] WIN_MASK    = 32'h07FF07FF;
   localparam logic [31:0] COLOUR_MASK = 32'h00FFFFFF;
   localparam logic [31:0] CTRL_MASK   = 32'h00FF07FF;
   localparam int B_KEYING    = 0;
   localparam int B_NEGATE    = 1;
   localparam int B_ADD_SEL   = 2;
   localparam int B_DIFF_SEL  = 3;
   localparam int B_ALPHA_CPL = 4;
   localparam int B_GA_ON     = 5;
   localparam int B_LA_ON     = 6;
   localparam int B_OVR_SRC   = 7;
   localparam int B_DMA_ON    = 8;
   localparam int B_LSB_COPY  = 9;
   localparam int B_DEST_KEY  = 10;
   localparam int GA_LSB      = 16;
   localparam int B_CH_ON     = 0;
   localparam int B_REFRESH   = 1;
   localparam int B_QPUSH     = 2;
   localparam int B_CH_OFF    = 0;
   localparam int B_CH_ABORT  = 8;
   localparam logic [7:0] COMP_MAX = 8'hFF;
   localparam logic [3:0] FULL_DEPTH = 4'h8;

   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } olb_rgb_s;

   typedef struct packed {
      logic [7:0] alpha;
      olb_rgb_s   rgb;
   } olb_argb_s;

   typedef enum logic [0:0] {
      OLB_IDLE  = 1'b0,
      OLB_FETCH = 1'b1
   } olb_fetch_e;
endpackage

//--- test/olb_overlay_blender_assertions.sv
// olb_checker: port-level properties of the overlay blender block.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module olb_checker #(
   parameter int ADDR_W = 32
) (
   input wire logic              clk_sys_in,
   input wire logic              rst_in,
   input wire logic [31:0]       reg_addr_in,
   input wire logic [31:0]       reg_wdata_in,
   input wire logic              reg_wr_in,
   input wire logic              reg_rd_in,
   input wire logic [31:0]       reg_rdata_out,
   input wire logic              frame_start_in,
   input wire logic              frame_done_in,
   input wire logic [11:0]       win_width_out,
   input wire logic [11:0]       win_height_out,
   input wire logic              queue_push_req_out,
   input wire logic              head_queued_in,
   input wire logic              channel_on_out,
   input wire logic              channel_abort_out,
   input wire logic [ADDR_W-1:0] base_addr_in,
   input wire logic              fetch_valid_out,
   input wire logic [ADDR_W-1:0] fetch_addr_out,
   input wire logic              fetch_ready_in,
   input wire logic              pix_valid_in,
   input wire logic              pix_valid_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   logic on_wr;
   logic ab_wr;
   logic wo_rd;
   assign on_wr = reg_wr_in && reg_addr_in == olb_pkg::ADDR_CHAN_ON;
   assign ab_wr = reg_wr_in && reg_addr_in == olb_pkg::ADDR_CHAN_OFF && reg_wdata_in[8];
   assign wo_rd = reg_rd_in && (reg_addr_in == olb_pkg::ADDR_CHAN_ON || reg_addr_in == olb_pkg::ADDR_CHAN_OFF);
   a_chan_start: assert property (
      on_wr && reg_wdata_in[0] |=> channel_on_out) else $error("channel not on after enable");
   a_wo_read: assert property (
      wo_rd |=> reg_rdata_out == 32'h0) else $error("write-only register read not zero");
   a_abort_now: assert property (
      ab_wr |=> channel_abort_out && !channel_on_out && !fetch_valid_out) else $error("abort not immediate");
   a_off_waits: assert property (
      channel_on_out && !frame_done_in && !ab_wr |=> channel_on_out) else $error("channel left before frame end");
   a_push_set: assert property (
      on_wr && reg_wdata_in[2] |=> queue_push_req_out) else $error("push request not raised");
   a_push_hold: assert property (
      queue_push_req_out && !head_queued_in && !ab_wr |=> queue_push_req_out) else $error("push request lost");
   a_size_plus: assert property (
      !$past(rst_in) |-> win_width_out != 12'h000 && win_height_out != 12'h000) else $error("window size zero");
   a_fetch_begin: assert property (
      $rose(fetch_valid_out) |-> $past(frame_start_in) && fetch_addr_out == $past(base_addr_in))
      else $error("fetch start wrong");
   a_addr_hold: assert property (
      fetch_valid_out && !fetch_ready_in && !ab_wr |=> fetch_valid_out && $stable(fetch_addr_out))
      else $error("fetch address moved while stalled");
   a_pix_delay: assert property (
      pix_valid_in |=> pix_valid_out) else $error("pixel result late");
endmodule // olb_checker
`default_nettype wire

//--- test/olb_mem_model.sv
// olb_mem_model: memory side of the fetch stream; accepts and logs addresses.
// assumes a level valid and a same-cycle ready on the system clock.
`timescale 1ns/1ps
`default_nettype none
module olb_mem_model (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   // fetch stream
   input  wire logic        fetch_valid_in,
   input  wire logic [31:0] fetch_addr_in,
   input  wire logic        slow_in,
   output logic             fetch_ready_out
);
   logic [31:0] got [$];
   logic        skip_reg;
   // slow mode stalls every other cycle, so a held address is exercised
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) skip_reg <= 1'b0;
      else skip_reg <= slow_in & ~skip_reg;
   end
   always @(posedge clk_sys_in) begin
      if (!rst_in && fetch_valid_in && fetch_ready_out) got.push_back(fetch_addr_in);
   end
   assign fetch_ready_out = fetch_valid_in & ~skip_reg;
endmodule // olb_mem_model
`default_nettype wire

//--- test/tb.sv
// tb: self-checking bench for the overlay blender block.
// assumes the memory model answers fetches and the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic clk_sys_in = 1'b0, rst_in = 1'b1, slow = 1'b0;
   logic [31:0] reg_addr_in = '0, reg_wdata_in = '0, base_addr_in = 32'h1000, reg_rdata_out, fetch_addr_out;
   logic reg_wr_in = 0, reg_rd_in = 0, frame_start_in = 0, frame_done_in = 0, head_queued_in = 0, pix_valid_in = 0;
   logic [10:0] win_left_in = '0, win_top_in = '0;
   logic [11:0] pixels_per_line_in = 12'hFFF, rows_per_frame_in = 12'hFFF, win_width_out, win_height_out;
   logic [3:0] comp_depth_in = 4'h8;
   olb_pkg::olb_argb_s mem_pix_in = '0;
   olb_pkg::olb_rgb_s under_pix_in = '0, pix_out;
   logic geometry_err_out, queue_push_req_out, channel_on_out, channel_abort_out;
   logic fetch_valid_out, fetch_ready_in, pix_valid_out;
   int failures = 0, total_checks = 0;
   olb_overlay_blender dut (.*);
   olb_mem_model mem (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .fetch_valid_in(fetch_valid_out),
      .fetch_addr_in(fetch_addr_out), .slow_in(slow), .fetch_ready_out(fetch_ready_in));
   always #2.5 clk_sys_in = ~clk_sys_in;
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   task automatic wr32(input logic [31:0] ad, input logic [31:0] d);
      @(posedge clk_sys_in);
      reg_addr_in <= ad;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask
   task automatic rd32(input logic [31:0] ad, output logic [31:0] d);
      @(posedge clk_sys_in);
      reg_addr_in <= ad;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_sys_in);
      d = reg_rdata_out;
   endtask
   task automatic pulse(input int w);
      @(posedge clk_sys_in);
      case (w)
         0: frame_start_in <= 1'b1;
         1: frame_done_in <= 1'b1;
         default: head_queued_in <= 1'b1;
      endcase
      @(posedge clk_sys_in);
      {frame_start_in, frame_done_in, head_queued_in} <= 3'b000;
      #1;
   endtask
   task automatic px(input logic [23:0] u, output olb_pkg::olb_rgb_s o);
      @(posedge clk_sys_in);
      pix_valid_in <= 1'b1;
      under_pix_in <= u;
      @(posedge clk_sys_in);
      pix_valid_in <= 1'b0;
      #1 o = pix_out;
   endtask
   task automatic t_regs;
      logic [31:0] ad, m, v;
      for (int i = 0; i < 7; i++) begin
         ad = olb_pkg::ADDR_WIN_SIZE + 32'(4 * i);
         m = i == 0 ? olb_pkg::WIN_MASK : i == 6 ? olb_pkg::CTRL_MASK : i > 2 ? olb_pkg::COLOUR_MASK : '1;
         rd32(ad, v);
         `CHK(v, 32'h0);
         wr32(ad, 32'hFFFFFFFF);
         rd32(ad, v);
         `CHK(v, m);
         wr32(ad, 32'h0);
      end
      rd32(olb_pkg::ADDR_CHAN_OFF, v);
      `CHK(v, 32'h0);
      rd32(32'hF8038300, v);
      `CHK(v, 32'h0);
   endtask
   task automatic t_chan;
      logic [31:0] v;
      wr32(olb_pkg::ADDR_CHAN_ON, 32'h1);
      `CHK(channel_on_out, 1'b1);
      wr32(olb_pkg::ADDR_CHAN_OFF, 32'h1);
      step(3);
      `CHK(channel_on_out, 1'b1);
      pulse(1);
      `CHK(channel_on_out, 1'b0);
      wr32(olb_pkg::ADDR_CHAN_ON, 32'h4);
      wr32(olb_pkg::ADDR_CHAN_ON, 32'h0);
      rd32(olb_pkg::ADDR_CHAN_STAT, v);
      `CHK(v[2:0], 3'b100);
      pulse(2);
      `CHK(queue_push_req_out, 1'b0);
      wr32(olb_pkg::ADDR_CHAN_ON, 32'h1);
      wr32(olb_pkg::ADDR_CHAN_OFF, 32'h100);
      `CHK({channel_abort_out, channel_on_out}, 2'b10);
   endtask
   task automatic t_fetch;
      logic [31:0] ex [4] = '{32'h1000, 32'h1004, 32'h1104, 32'h1108};
      logic [31:0] v;
      int n;
      wr32(olb_pkg::ADDR_WIN_SIZE, 32'h00010001);
      wr32(olb_pkg::ADDR_ROW_STEP, 32'h100);
      wr32(olb_pkg::ADDR_PIX_STEP, 32'h4);
      wr32(olb_pkg::ADDR_CHAN_ON, 32'h3);
      rd32(olb_pkg::ADDR_CHAN_STAT, v);
      `CHK(v[2:0], 3'b011);
      pulse(0);
      step(1);
      `CHK({win_width_out, win_height_out}, 24'h002002);
      win_left_in <= 11'h1;
      pixels_per_line_in <= 12'h1;
      step(2);
      `CHK(geometry_err_out, 1'b1);
      pixels_per_line_in <= 12'h2;
      step(2);
      `CHK(geometry_err_out, 1'b0);
      win_top_in <= 11'h1;
      rows_per_frame_in <= 12'h1;
      step(2);
      `CHK(geometry_err_out, 1'b1);
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h100);
      slow <= 1'b1;
      pulse(0);
      for (n = 0; n < 60 && fetch_valid_out; n++) step(1);
      if (n == 60) begin
         failures++;
         end_of_test();
      end
      `CHK(mem.got.size() >= 4, 1'b1);
      for (int i = 0; i < 4; i++) `CHK(mem.got[i], ex[i]);
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h0);
      slow <= 1'b0;
   endtask
   task automatic t_key;
      olb_pkg::olb_rgb_s o;
      wr32(olb_pkg::ADDR_DEF_COLOUR, 32'h123456);
      wr32(olb_pkg::ADDR_KEY_COLOUR, 32'h123457);
      wr32(olb_pkg::ADDR_KEY_MASK, 32'hFFFFFE);
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h1);
      px(24'hA5A5A5, o);
      `CHK(o, 24'hA5A5A5);
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h0);
      px(24'hA5A5A5, o);
      `CHK(o, 24'h123456);
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h401);
      px(24'hA5A5A5, o);
      `CHK(o, 24'hA5A5A5);
      wr32(olb_pkg::ADDR_KEY_MASK, 32'hFFFFFF);
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h1);
      px(24'hA5A5A5, o);
      `CHK(o, 24'h123456);
   endtask
   task automatic t_blend;
      olb_pkg::olb_rgb_s o;
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h00800020);
      px(24'h0, o);
      `CHK(o, 24'h091A2B);
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h4);
      px(24'h0, o);
      `CHK(o, 24'h1B4E81);
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h6);
      px(24'h0, o);
      `CHK(o, 24'h2D82D7);
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h4);
      px(24'h0, o);
      `CHK(o, 24'hE4B17E);
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h00800038);
      px(24'h0, o);
      `CHK(o, 24'h7A726A);
      mem_pix_in <= 32'h801F100F;
      comp_depth_in <= 4'h5;
      wr32(olb_pkg::ADDR_BLEND_CTRL, 32'h3C0);
      px(24'h0, o);
      `CHK(o, 24'h80443C);
   endtask
   task automatic end_of_test;
      if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      t_regs();
      t_chan();
      t_fetch();
      t_key();
      t_blend();
      end_of_test();
   end
endmodule // tb
bind olb_overlay_blender olb_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire
